/* include/mode_log_pkg.sv */
/*
  Constants for the mode and violation log block: register indices, field
  positions, reset values and record codes.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
// Function
// - Mode select bit loads the mode pin level when external reset rises.
// - Mode select bit sets chip mode; mode register bits 6 to 0 read zero.
// - Software writes to the mode register act only for an allowed transition.
// - Only special single-chip to normal single-chip is accepted, never back.
// - Writing 0xFFFF across both code bytes clears them; other values do nothing.
// - High code byte upper nibble holds initiator: none, processor, converters, trigger.
// - High code byte lower nibble holds target: none, registers, RAM, EEPROM, flash, row.
// - Low code byte upper nibble holds access type: none, opcode, vector, load, store.
// - Low code byte lower nibble holds violation type: none, illegal, ECC.
// - A violation or uncorrectable ECC error loads a non-zero code record.
// - The same cycle also captures program counter and condition-code bits.
// - While the code is non-zero, code, counter and flags stay frozen.
// - High flags byte bit 7 holds the user state, read-only.
// - Low flags byte bit 6 holds the X-interrupt mask, read-only.
// - Low flags byte bit 4 holds the I-interrupt mask, read-only.
// - 24-bit counter capture holds the faulting instruction address.
// - Block is active only in run and wait; no bus activity in stop.
package mode_log_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [1:0]  RESP_OKAY = 2'h0;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_OPERATING_MODE = 10'h070;
  localparam logic [IDX_W-1:0] IDX_VCODE_HIGH     = 10'h080;
  localparam logic [IDX_W-1:0] IDX_VCODE_LOW      = 10'h081;
  localparam logic [IDX_W-1:0] IDX_FLAGS_HIGH     = 10'h082;
  localparam logic [IDX_W-1:0] IDX_FLAGS_LOW      = 10'h083;
  localparam logic [IDX_W-1:0] IDX_PC_HIGH        = 10'h085;
  localparam logic [IDX_W-1:0] IDX_PC_MID         = 10'h086;
  localparam logic [IDX_W-1:0] IDX_PC_LOW         = 10'h087;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_SEL_BIT  = 7;
  localparam int unsigned USER_BIT      = 7;
  localparam int unsigned XIRQ_BIT      = 6;
  localparam int unsigned IRQ_BIT       = 4;
  localparam logic        MODE_SPECIAL  = 1'h0;
  localparam logic        MODE_NORMAL   = 1'h1;
  localparam logic [7:0]  CLEAR_BYTE    = 8'hFF;
  localparam logic [15:0] CLEAR_WORD    = 16'hFFFF;
  localparam logic [1:0]  LANE_PAIR     = 2'h3;
  localparam logic [15:0] CODE_NONE     = 16'h0000;
  localparam logic [23:0] PC_RESET      = 24'h000000;

  // ----------------------------------------------------------------------
  // Record codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] INIT_NONE = 4'h0;
  localparam logic [3:0] INIT_CPU  = 4'h1;
  localparam logic [3:0] INIT_CONVERTER_ZERO = 4'h3;
  localparam logic [3:0] INIT_CONVERTER_ONE  = 4'h4;
  localparam logic [3:0] INIT_TRIGGER_UNIT   = 4'h5;
  localparam logic [3:0] TGT_NONE = 4'h0;
  localparam logic [3:0] TGT_REGS = 4'h1;
  localparam logic [3:0] TGT_RAM  = 4'h2;
  localparam logic [3:0] TGT_EEPROM = 4'h3;
  localparam logic [3:0] TGT_FLASH  = 4'h4;
  localparam logic [3:0] TGT_INFORMATION_ROW = 4'h5;
  localparam logic [3:0] ACC_NONE   = 4'h0;
  localparam logic [3:0] ACC_OPCODE = 4'h1;
  localparam logic [3:0] ACC_VECTOR = 4'h2;
  localparam logic [3:0] ACC_LOAD   = 4'h3;
  localparam logic [3:0] ACC_STORE  = 4'h4;
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_ILLEGAL = 4'h1;
  localparam logic [3:0] ERR_ECC     = 4'h2;

endpackage

/* include/record_if.sv */
/*
  Interface between the register block and the violation recorder.
  Assumes both ends run on the same clock.
*/
interface record_if;
  logic        ev_valid;
  logic [15:0] ev_code;
  logic        ev_user;
  logic        ev_xirq;
  logic        ev_irq;
  logic [23:0] ev_pc;
  logic        clear_req;
  logic [15:0] code_q;
  logic        user_q;
  logic        xirq_q;
  logic        irq_q;
  logic [23:0] pc_q;

  modport recorder (
    input  ev_valid, ev_code, ev_user, ev_xirq, ev_irq, ev_pc, clear_req,
    output code_q, user_q, xirq_q, irq_q, pc_q
  );
  modport regs (
    output ev_valid, ev_code, ev_user, ev_xirq, ev_irq, ev_pc, clear_req,
    input  code_q, user_q, xirq_q, irq_q, pc_q
  );
endinterface

/* hw/violation_recorder.sv */
/*
  Holds the first violation record: code, condition-code bits, counter.
  Assumes events arrive on aclk as one-cycle pulses and are gated for stop.
*/
module violation_recorder (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Record port
  record_if.recorder rec
);

  // ----------------------------------------------------------------------
  // Capture control
  // ----------------------------------------------------------------------
  logic held;
  logic load;

  assign held = (rec.code_q != mode_log_pkg::CODE_NONE);
  // A zero code would look like an empty log, so it is never loaded
  assign load = rec.ev_valid && (rec.ev_code != mode_log_pkg::CODE_NONE) && !held;

  // ----------------------------------------------------------------------
  // Code register
  // ----------------------------------------------------------------------
  // A clear and a new event in one cycle: the event wins, since held is
  // still set only until the clear lands, so the load path is checked first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rec.code_q <= mode_log_pkg::CODE_NONE;
    else if (ce)
    begin
      if (rec.ev_valid && (rec.ev_code != mode_log_pkg::CODE_NONE) && (!held || rec.clear_req))
        rec.code_q <= rec.ev_code;
      else if (rec.clear_req)
        rec.code_q <= mode_log_pkg::CODE_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Processor state capture
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rec.user_q <= 1'h0;
      rec.xirq_q <= 1'h0;
      rec.irq_q  <= 1'h0;
      rec.pc_q   <= mode_log_pkg::PC_RESET;
    end
    else if (ce && (load || (rec.clear_req && rec.ev_valid &&
                    (rec.ev_code != mode_log_pkg::CODE_NONE))))
    begin
      rec.user_q <= rec.ev_user;
      rec.xirq_q <= rec.ev_xirq;
      rec.irq_q  <= rec.ev_irq;
      rec.pc_q   <= rec.ev_pc;
    end
  end

endmodule // violation_recorder

/* hw/mode_and_violation_log.sv */
/*
  Mode register and access violation log behind an AXI4-Lite slave.
  Assumes mode_pin and ext_reset_n come from pins; violation reports and
  stop_mode come from logic on aclk.
*/
module mode_and_violation_log (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Pins
  input  wire logic        ext_reset_n,
  input  wire logic        mode_pin,
  // Power state
  input  wire logic        stop_mode,
  // Violation report
  input  wire logic        viol_valid,
  input  wire logic [3:0]  initiator_code,
  input  wire logic [3:0]  target_code,
  input  wire logic [3:0]  access_type_code,
  input  wire logic [3:0]  error_type_code,
  input  wire logic        cpu_user_state,
  input  wire logic        cpu_xirq_mask,
  input  wire logic        cpu_irq_mask,
  input  wire logic [23:0] cpu_program_counter,
  // Status
  output logic             mode_select,
  output logic             violation_held,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  record_if rec ();

  logic [1:0]  rst_sync_q;
  logic [1:0]  mode_sync_q;
  logic        rst_seen_q;
  logic        mode_q;
  logic        aw_held_q;
  logic [9:0]  aw_idx_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic        clear_armed_q;
  logic        active;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_lane0;
  logic [7:0]  wr_byte;
  logic        clear_now;
  logic [9:0]  rd_idx;
  logic [31:0] rd_value;
  logic        strap_edge;
  logic        wr_mode;
  logic        wr_code_high;
  logic        wr_code_low;
  logic        byte_ones;
  logic        word_ones;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Both pins are asynchronous; only the second stage is ever looked at
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_sync_q  <= 2'h0;
      mode_sync_q <= 2'h0;
    end
    else if (ce)
    begin
      rst_sync_q  <= {rst_sync_q[0], ext_reset_n};
      mode_sync_q <= {mode_sync_q[0], mode_pin};
    end
  end

  // Remembers the last synchronised reset level for the rising-edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_seen_q <= 1'h0;
    else if (ce)
      rst_seen_q <= rst_sync_q[1];
  end

  // The strap is taken once per release of the external reset
  assign strap_edge = rst_sync_q[1] && !rst_seen_q;

  // ----------------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------------
  assign active   = !stop_mode;
  assign wr_fire  = aw_held_q && w_held_q && !bvalid_q && active;
  assign wr_lane0 = wr_fire && w_strb_q[0];
  assign wr_byte  = w_data_q[7:0];

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // Byte lane 0 carries register data (lane 1 only in the 0xFFFF clear), so each decode needs its strobe
  assign wr_mode      = wr_lane0 && (aw_idx_q == mode_log_pkg::IDX_OPERATING_MODE);
  assign wr_code_high = wr_lane0 && (aw_idx_q == mode_log_pkg::IDX_VCODE_HIGH);
  assign wr_code_low  = wr_lane0 && (aw_idx_q == mode_log_pkg::IDX_VCODE_LOW);
  assign byte_ones    = (wr_byte == mode_log_pkg::CLEAR_BYTE);
  assign word_ones    = (w_strb_q[1:0] == mode_log_pkg::LANE_PAIR) &&
                        (w_data_q[15:0] == mode_log_pkg::CLEAR_WORD);

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  // The pin level is taken two cycles late, so a strap must stay stable
  // for a few bus clocks around the release of the external reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= mode_log_pkg::MODE_SPECIAL;
    else if (ce)
    begin
      if (strap_edge)
        mode_q <= mode_sync_q[1];
      else if (wr_mode && (mode_q == mode_log_pkg::MODE_SPECIAL) &&
               (wr_byte[mode_log_pkg::MODE_SEL_BIT] == mode_log_pkg::MODE_NORMAL))
        mode_q <= mode_log_pkg::MODE_NORMAL;
    end
  end

  assign mode_select = mode_q;

  // ----------------------------------------------------------------------
  // Clear sequence for the code bytes
  // ----------------------------------------------------------------------
  // 0xFF to the high byte arms; 0xFF to the low byte next clears. A single
  // word write of 0xFFFF to the high register clears at once.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clear_armed_q <= 1'h0;
    else if (ce && wr_fire)
      clear_armed_q <= wr_code_high && byte_ones;
  end

  always_comb
  begin
    clear_now = 1'h0;
    if (wr_fire)
    begin
      if (wr_code_high && word_ones)
        clear_now = 1'h1;
      else if (clear_armed_q && wr_code_low && byte_ones)
        clear_now = 1'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Violation recorder
  // ----------------------------------------------------------------------
  assign rec.ev_valid  = viol_valid && active;
  assign rec.ev_code   = {initiator_code, target_code, access_type_code, error_type_code};
  assign rec.ev_user   = cpu_user_state;
  assign rec.ev_xirq   = cpu_xirq_mask;
  assign rec.ev_irq    = cpu_irq_mask;
  assign rec.ev_pc     = cpu_program_counter;
  assign rec.clear_req = clear_now;

  violation_recorder u_recorder (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .rec     (rec.recorder)
  );

  assign violation_held = (rec.code_q != mode_log_pkg::CODE_NONE);

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  // Address and data are held independently so either may come first
  // Held off while ce is low: a beat taken then would be missed by frozen state
  assign s_axi_awready = !aw_held_q && active && ce;
  assign s_axi_wready  = !w_held_q && active && ce;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'h0;
      aw_idx_q  <= 10'h000;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'h1;
        aw_idx_q  <= s_axi_awaddr[mode_log_pkg::IDX_LSB +: mode_log_pkg::IDX_W];
      end
      else if (wr_fire)
        aw_held_q <= 1'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'h1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'h0;
    end
  end

  // Every write is answered OKAY; reserved locations simply ignore it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bvalid_q <= 1'h0;
    else if (ce)
    begin
      if (wr_fire)
        bvalid_q <= 1'h1;
      else if (s_axi_bready)
        bvalid_q <= 1'h0;
    end
  end

  // A response shown while frozen could be taken twice, so it is hidden
  assign s_axi_bvalid = bvalid_q && ce;
  assign s_axi_bresp  = mode_log_pkg::RESP_OKAY;

  // ----------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------
  assign s_axi_arready = !rvalid_q && active && ce;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[mode_log_pkg::IDX_LSB +: mode_log_pkg::IDX_W];

  always_comb
  begin
    rd_value = 32'h00000000;
    unique case (rd_idx)
      mode_log_pkg::IDX_OPERATING_MODE:
        rd_value[mode_log_pkg::MODE_SEL_BIT] = mode_q;
      mode_log_pkg::IDX_VCODE_HIGH:
        rd_value[7:0] = rec.code_q[15:8];
      mode_log_pkg::IDX_VCODE_LOW:
        rd_value[7:0] = rec.code_q[7:0];
      mode_log_pkg::IDX_FLAGS_HIGH:
        rd_value[mode_log_pkg::USER_BIT] = rec.user_q;
      mode_log_pkg::IDX_FLAGS_LOW:
      begin
        rd_value[mode_log_pkg::XIRQ_BIT] = rec.xirq_q;
        rd_value[mode_log_pkg::IRQ_BIT]  = rec.irq_q;
      end
      mode_log_pkg::IDX_PC_HIGH:
        rd_value[7:0] = rec.pc_q[23:16];
      mode_log_pkg::IDX_PC_MID:
        rd_value[7:0] = rec.pc_q[15:8];
      mode_log_pkg::IDX_PC_LOW:
        rd_value[7:0] = rec.pc_q[7:0];
      default:
        rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'h0;
      rdata_q  <= 32'h00000000;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rvalid_q <= 1'h1;
        rdata_q  <= rd_value;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'h0;
    end
  end

  assign s_axi_rvalid = rvalid_q && ce;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = mode_log_pkg::RESP_OKAY;

endmodule // mode_and_violation_log

/* testbench/mode_log_props.sv */
/*
  Port checker for mode_and_violation_log.
  Assumes one clock aclk and a synchronous active-low aresetn.
*/
module mode_log_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // Pins and reports
  input wire logic        ext_reset_n,
  input wire logic        stop_mode,
  input wire logic        viol_valid,
  input wire logic [3:0]  error_type_code,
  // Status
  input wire logic        mode_select,
  input wire logic        violation_held,
  // Bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_stop_read: assert property (stop_mode |-> !s_axi_arready)
    else $error("Read accepted in stop");
  a_stop_write: assert property (stop_mode |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted in stop");
  a_event_loads: assert property (viol_valid && ce && !stop_mode && !violation_held
    && error_type_code != 4'h0 |=> violation_held)
    else $error("Violation not recorded");
  a_held_cause: assert property ($rose(violation_held)
    |-> $past(viol_valid) && !$past(stop_mode))
    else $error("Record appeared without report");
  a_clear_write: assert property ($fell(violation_held) |-> $rose(s_axi_bvalid))
    else $error("Record dropped without write");
  // Only an external reset may bring the mode back to special
  a_mode_fall: assert property ($fell(mode_select)
    |-> !$past(ext_reset_n, 3) || !$past(ext_reset_n, 4) || !$past(ext_reset_n, 5))
    else $error("Mode returned to special");
  a_mode_read: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 12'h1C0
    |-> s_axi_rdata == {24'h000000, $past(mode_select), 7'h00})
    else $error("Mode read wrong");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero");
  a_resp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("Write answered with error");
endmodule // mode_log_props

bind mode_and_violation_log mode_log_props chk_u (.aclk, .aresetn, .ce, .ext_reset_n,
  .stop_mode, .viol_valid, .error_type_code, .mode_select, .violation_held, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid);

/* testbench/violation_source.sv */
/*
  Model of the processor side reporting faulty accesses.
  Assumes reports are one-cycle pulses on aclk.
*/
module violation_source (
  // Clock
  input wire logic   aclk,
  // Report
  output logic        viol_valid,
  output logic [15:0] rep_code,
  output logic        rep_user,
  output logic        rep_xirq,
  output logic        rep_irq,
  output logic [23:0] rep_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    viol_valid = 1'b0;
    rep_code = 16'h0000;
    {rep_user, rep_xirq, rep_irq} = 3'h0;
    rep_pc = 24'h000000;
  end
  // Fields scrambled after the pulse so a stale value is never caught
  task automatic report(input logic [15:0] c, input logic [2:0] f, input logic [23:0] p);
    @(posedge aclk);
    viol_valid <= 1'b1;
    rep_code <= c;
    {rep_user, rep_xirq, rep_irq} <= f;
    rep_pc <= p;
    @(posedge aclk);
    viol_valid <= 1'b0;
    rep_code <= ~c;
    {rep_user, rep_xirq, rep_irq} <= ~f;
    rep_pc <= ~p;
  endtask
endmodule // violation_source

/* testbench/tb_mode_and_violation_log.sv */
/*
  Self-checking bench for mode_and_violation_log over AXI4-Lite.
  Assumes the package, the checker and violation_source are compiled first.
*/
module tb_mode_and_violation_log;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_MODE = {mode_log_pkg::IDX_OPERATING_MODE, 2'h0};
  localparam logic [11:0] A_CH   = {mode_log_pkg::IDX_VCODE_HIGH, 2'h0};
  localparam logic [11:0] A_CL   = {mode_log_pkg::IDX_VCODE_LOW, 2'h0};
  localparam logic [11:0] A_FH   = {mode_log_pkg::IDX_FLAGS_HIGH, 2'h0};
  localparam logic [11:0] A_FL   = {mode_log_pkg::IDX_FLAGS_LOW, 2'h0};
  localparam logic [11:0] A_PC   = {mode_log_pkg::IDX_PC_HIGH, 2'h0};
  logic        aclk, aresetn, ce, ext_reset_n, mode_pin, stop_mode;
  logic        viol_valid, cpu_user_state, cpu_xirq_mask, cpu_irq_mask;
  logic [15:0] rep_code;
  logic [23:0] rep_pc, pcv;
  logic        mode_select, violation_held;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [2:0]  f;
  logic [15:0] codes [5] = '{16'h1111, 16'h3222, 16'h4331, 16'h5442, 16'h1531};
  int          miscompares, n_tests, i, p;

  always #50 aclk = ~aclk;

  violation_source src_u (.aclk, .viol_valid, .rep_code, .rep_user(cpu_user_state),
    .rep_xirq(cpu_xirq_mask), .rep_irq(cpu_irq_mask), .rep_pc);
  mode_and_violation_log dut_u (.aclk, .aresetn, .ce, .ext_reset_n, .mode_pin, .stop_mode,
    .viol_valid, .initiator_code(rep_code[15:12]), .target_code(rep_code[11:8]),
    .access_type_code(rep_code[7:4]), .error_type_code(rep_code[3:0]), .cpu_user_state,
    .cpu_xirq_mask, .cpu_irq_mask, .cpu_program_counter(rep_pc), .mode_select,
    .violation_held, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ----------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // A wait that runs out ends the run
  task automatic tmo(input int k);
    if (k >= 50)
    begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    tmo(k);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    got = rdata;
    rready <= 1'b0;
    tmo(k);
    chk(got, e);
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {aclk, aresetn, ext_reset_n, mode_pin, stop_mode} = 5'h00;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    miscompares = 0;
    n_tests = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    ext_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(A_MODE, 32'h0);
    wr(A_MODE, 32'h7F, 4'h1);
    rd(A_MODE, 32'h0);
    wr(A_MODE, 32'hFF, 4'h1);
    rd(A_MODE, 32'h80);
    wr(A_MODE, 32'h0, 4'h1);
    rd(A_MODE, 32'h80);
    for (p = 0; p < 2; p++)
    begin
      ext_reset_n <= 1'b0;
      mode_pin <= p[0];
      repeat (4) @(posedge aclk);
      ext_reset_n <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(A_MODE, {24'h0, p[0], 7'h0});
    end
    $display("Mode tests done");
    wr(A_FH, 32'hFF, 4'h1);
    rd(A_FH, 32'h0);
    wr(12'h210, 32'hFF, 4'h1);
    rd(12'h210, 32'h0);
    rd(12'h3FC, 32'h0);
    $display("Reserved tests done");
    for (i = 0; i < 5; i++)
    begin
      f = 3'(i + 3);
      pcv = 24'h0F1E2D + 24'(i) * 24'h111111;
      src_u.report(codes[i], f, pcv);
      rd(A_CH, {24'h0, codes[i][15:8]});
      rd(A_CL, {24'h0, codes[i][7:0]});
      rd(A_FH, {24'h0, f[2], 7'h0});
      rd(A_FL, {24'h0, 1'b0, f[1], 1'b0, f[0], 4'h0});
      rd(A_PC, {24'h0, pcv[23:16]});
      rd(A_PC + 12'h4, {24'h0, pcv[15:8]});
      src_u.report(16'h1241, ~f, ~pcv);
      rd(A_CL, {24'h0, codes[i][7:0]});
      rd(A_PC + 12'h8, {24'h0, pcv[7:0]});
      wr(A_CH, 32'hFFFE, 4'h3);
      rd(A_CH, {24'h0, codes[i][15:8]});
      if (i[0])
        wr(A_CH, 32'hFFFF, 4'h3);
      else
      begin
        wr(A_CH, 32'hFF, 4'h1);
        wr(A_CL, 32'hFF, 4'h1);
      end
      rd(A_CH, 32'h0);
      rd(A_CL, 32'h0);
    end
    $display("Record tests done");
    stop_mode <= 1'b1;
    src_u.report(16'h1111, 3'h7, 24'h123456);
    stop_mode <= 1'b0;
    rd(A_CH, 32'h0);
    $display("Stop test done");
    wrap_up();
  end
endmodule // tb_mode_and_violation_log
